// >>> design/pkt_cfg_pkg.sv
// Package with register map, field layout and reset values of the packet configuration slice.
package pkt_cfg_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CODING_CTRL   = 8'h33;
    localparam logic [7:0] ADDR_LEN_HIGH      = 8'h34;
    localparam logic [7:0] ADDR_LEN_LOW       = 8'h35;
    localparam logic [7:0] ADDR_SYNC_4        = 8'h36;
    localparam logic [7:0] ADDR_SYNC_3        = 8'h37;
    localparam logic [7:0] ADDR_SYNC_2        = 8'h38;
    localparam logic [7:0] ADDR_SYNC_1        = 8'h39;
    localparam logic [7:0] ADDR_QUALITY       = 8'h3a;
    localparam logic [7:0] ADDR_MBUS_PREAMBLE = 8'h3b;
    localparam logic [7:0] ADDR_MBUS_POSTAMB  = 8'h3c;
    localparam logic [7:0] ADDR_METER_BUS_CONTROL     = 8'h3d;
    localparam logic [7:0] ADDR_RX_AF         = 8'h3e;
    localparam logic [7:0] ADDR_RX_AE         = 8'h3f;
    localparam logic [7:0] ADDR_TX_AF         = 8'h40;
    localparam logic [7:0] ADDR_TX_AE         = 8'h41;
    localparam logic [7:0] ADDR_CTRL_MASK_0   = 8'h42;
    localparam logic [7:0] ADDR_LEN_MODE      = 8'h32;

    // ------------------------------------------------------------------
    // Writable bit masks (reserved bits cleared)
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_CODING_CTRL = 8'h1d;
    localparam logic [7:0] MASK_METER_BUS_CONTROL   = 8'h0e;
    localparam logic [7:0] MASK_FIFO_LEVEL  = 8'h7f;
    localparam logic [7:0] MASK_LEN_MODE    = 8'h01;
    localparam logic [7:0] MASK_FULL        = 8'hff;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CODING_CTRL = 8'h00;
    localparam logic [7:0] RST_LEN_HIGH    = 8'h00;
    localparam logic [7:0] RST_LEN_LOW     = 8'h14;
    localparam logic [7:0] RST_SYNC        = 8'h88;
    localparam logic [7:0] RST_QUALITY     = 8'h02;
    localparam logic [7:0] RST_MBUS_AMBLE  = 8'h20;
    localparam logic [7:0] RST_METER_BUS_CONTROL   = 8'h00;
    localparam logic [7:0] RST_FIFO_LEVEL  = 8'h30;
    localparam logic [7:0] RST_CTRL_MASK   = 8'h00;
    localparam logic [7:0] RST_LEN_MODE    = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int POS_WHITEN     = 4;
    localparam int POS_SRC_LO     = 2;
    localparam int POS_FEC        = 0;
    localparam int POS_SYNC_QUALITY_THRESHOLD_LO  = 6;
    localparam int POS_PREAMBLE_QUALITY_THRESHOLD_LO  = 2;
    localparam int POS_SYNC_QUALITY_CHECK_ENABLE     = 1;
    localparam int POS_PREAMBLE_QUALITY_CHECK_ENABLE     = 0;
    localparam int POS_SUBMODE_LO = 1;
    localparam int POS_LEN_MODE   = 0;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_NORMAL = 2'h0,
        SRC_FIFO   = 2'h1,
        SRC_PIN    = 2'h2,
        SRC_PN9    = 2'h3
    } tx_source_t;

    typedef enum logic [2:0] {
        SUB_LONG_HEADER    = 3'h0,
        SUB_OTHER_TO_METER = 3'h1,
        SUB_METER_TO_OTHER = 3'h3,
        SUB_SHORT_HEADER   = 3'h5
    } sub_mode_t;

    // Host access strobe group.
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // Decoded configuration toward the packet handler.
    typedef struct packed {
        logic        whitening_enable;
        tx_source_t  transmit_data_source;
        logic        error_correction_enable;
        logic        length_mode_select;
        logic [15:0] packet_length;
        logic [31:0] sync_pattern;
        logic [1:0]  sync_quality_threshold;
        logic [3:0]  preamble_quality_threshold;
        logic        sync_quality_check_enable;
        logic        preamble_quality_check_enable;
        logic [7:0]  meter_bus_preamble_length;
        logic [7:0]  meter_bus_postamble_length;
        sub_mode_t   meter_bus_sub_mode;
        logic        sub_mode_error;
        logic [6:0]  rx_fifo_almost_full_level;
        logic [6:0]  rx_fifo_almost_empty_level;
        logic [6:0]  tx_fifo_almost_full_level;
        logic [6:0]  tx_fifo_almost_empty_level;
        logic [7:0]  control_field_mask_first;
        logic        control_filter_active;
    } pkt_cfg_t;

endpackage

// >>> design/cfg_reg8.sv
// One eight-bit configuration register with reset value and writable-bit mask.
`timescale 1ns/100ps
`default_nettype none
module cfg_reg8 #(
    parameter logic [7:0] ADDR     = 8'h00,
    parameter logic [7:0] RST_VAL  = 8'h00,
    parameter logic [7:0] WR_MASK  = 8'hff
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Host write
    input  wire logic       write,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    // Stored value
    output logic      [7:0] value
);
    logic [7:0] value_ff;
    logic [7:0] nxt_value;

    always_comb begin
        nxt_value = value_ff;
        if (write && addr == ADDR) begin
            // Reserved positions stay zero whatever is written.
            nxt_value = wdata & WR_MASK;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            value_ff <= RST_VAL & WR_MASK;
        end else begin
            value_ff <= nxt_value;
        end
    end

    assign value = value_ff;
endmodule
`default_nettype wire

// >>> design/packet_config_register_slice.sv
// Packet and protocol configuration register slice with host access and decoded outputs.
// Functional notes
// [RULE_01] Whitening enable bit turns whitening and de-whitening on; clear means none.
// [RULE_02] Two-bit source field picks normal, FIFO, pin or PN9 transmit data.
// [RULE_03] Error-correction bit enables convolutional encoding and Viterbi decoding together.
// [RULE_04] Packet length is sixteen bits: high byte at 0x34, low byte at 0x35.
// [RULE_05] Sync quality threshold in bits 7:6; bit 1 enables check, set at reset.
// [RULE_06] Preamble quality threshold in bits 5:2; bit 0 enables check, clear at reset.
// [RULE_07] Meter bus preamble length is the eight-bit value in 01 chip pairs.
// [RULE_08] Meter bus postamble length is the eight-bit value in 01 chip pairs.
// [RULE_09] Sub-mode accepts only 0, 1, 3 or 5; host writes no others (other values are stored and raise sub_mode_error).
// [RULE_10] Receive FIFO keeps seven-bit almost-full and almost-empty thresholds.
// [RULE_11] Transmit FIFO keeps seven-bit almost-full and almost-empty thresholds.
// [RULE_12] First control mask filters received packets; zero mask disables filtering.
// [RULE_13] Length mode bit selects fixed (0) or variable (1) packet length.
// [RULE_14] Reserved bits read as zero and ignore writes.
// [RULE_15] Registers reset to defaults and change only on a host write.
`timescale 1ns/100ps
`default_nettype none
module packet_config_register_slice (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // Host register access
    input  wire pkt_cfg_pkg::host_req_t host_req,
    output logic                       rdata_valid,
    output logic                 [7:0] rdata,
    output logic                       addr_hit,
    // Decoded configuration
    output pkt_cfg_pkg::pkt_cfg_t      cfg
);
    import pkt_cfg_pkg::*;

    localparam int NREG = 17;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    localparam logic [NREG*8-1:0] ADDRS = {
        ADDR_LEN_MODE, ADDR_CTRL_MASK_0, ADDR_TX_AE, ADDR_TX_AF, ADDR_RX_AE, ADDR_RX_AF,
        ADDR_METER_BUS_CONTROL, ADDR_MBUS_POSTAMB, ADDR_MBUS_PREAMBLE, ADDR_QUALITY,
        ADDR_SYNC_1, ADDR_SYNC_2, ADDR_SYNC_3, ADDR_SYNC_4,
        ADDR_LEN_LOW, ADDR_LEN_HIGH, ADDR_CODING_CTRL};
    localparam logic [NREG*8-1:0] RSTS = {
        RST_LEN_MODE, RST_CTRL_MASK, RST_FIFO_LEVEL, RST_FIFO_LEVEL, RST_FIFO_LEVEL,
        RST_FIFO_LEVEL, RST_METER_BUS_CONTROL, RST_MBUS_AMBLE, RST_MBUS_AMBLE, RST_QUALITY,
        RST_SYNC, RST_SYNC, RST_SYNC, RST_SYNC, RST_LEN_LOW, RST_LEN_HIGH, RST_CODING_CTRL};
    localparam logic [NREG*8-1:0] MASKS = {
        MASK_LEN_MODE, MASK_FULL, MASK_FIFO_LEVEL, MASK_FIFO_LEVEL, MASK_FIFO_LEVEL,
        MASK_FIFO_LEVEL, MASK_METER_BUS_CONTROL, MASK_FULL, MASK_FULL, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_CODING_CTRL};

    logic [7:0] regs [NREG];

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            cfg_reg8 #(
                .ADDR    (ADDRS[gi*8 +: 8]),
                .RST_VAL (RSTS[gi*8 +: 8]),
                .WR_MASK (MASKS[gi*8 +: 8])
            ) u_reg (
                .clock (clock),
                .reset (reset),
                .write (host_req.write),  // [RULE_15] [RULE_14]
                .addr  (host_req.addr),
                .wdata (host_req.wdata),
                .value (regs[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic       rdata_valid_ff;
    logic [7:0] rdata_ff;
    logic       addr_hit_ff;
    logic       nxt_rdata_valid;
    logic [7:0] nxt_rdata;
    logic       nxt_addr_hit;
    logic       hit;

    always_comb begin
        hit = 1'b0;
        nxt_rdata = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (host_req.addr == ADDRS[i*8 +: 8]) begin
                hit = 1'b1;
                nxt_rdata = regs[i];  // [RULE_14]
            end
        end
        if (!host_req.read) begin
            nxt_rdata = rdata_ff;
        end
        nxt_rdata_valid = host_req.read;
        nxt_addr_hit = (host_req.read || host_req.write) ? hit : addr_hit_ff;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_valid_ff <= 1'b0;
            rdata_ff <= 8'h00;
            addr_hit_ff <= 1'b0;
        end else begin
            rdata_valid_ff <= nxt_rdata_valid;
            rdata_ff <= nxt_rdata;
            addr_hit_ff <= nxt_addr_hit;
        end
    end

    // ------------------------------------------------------------------
    // Decoded configuration
    // ------------------------------------------------------------------
    pkt_cfg_t cfg_ff;
    pkt_cfg_t nxt_cfg;
    logic [2:0] sub_raw;

    always_comb begin
        nxt_cfg = '0;
        nxt_cfg.whitening_enable = regs[0][POS_WHITEN];  // [RULE_01]
        nxt_cfg.transmit_data_source = tx_source_t'(regs[0][POS_SRC_LO +: 2]);  // [RULE_02]
        nxt_cfg.error_correction_enable = regs[0][POS_FEC];  // [RULE_03]
        nxt_cfg.packet_length = {regs[1], regs[2]};  // [RULE_04]
        nxt_cfg.sync_pattern = {regs[3], regs[4], regs[5], regs[6]};
        nxt_cfg.sync_quality_threshold = regs[7][POS_SYNC_QUALITY_THRESHOLD_LO +: 2];  // [RULE_05]
        nxt_cfg.sync_quality_check_enable = regs[7][POS_SYNC_QUALITY_CHECK_ENABLE];  // [RULE_05]
        nxt_cfg.preamble_quality_threshold = regs[7][POS_PREAMBLE_QUALITY_THRESHOLD_LO +: 4];  // [RULE_06]
        nxt_cfg.preamble_quality_check_enable = regs[7][POS_PREAMBLE_QUALITY_CHECK_ENABLE];  // [RULE_06]
        nxt_cfg.meter_bus_preamble_length = regs[8];  // [RULE_07]
        nxt_cfg.meter_bus_postamble_length = regs[9];  // [RULE_08]
        sub_raw = regs[10][POS_SUBMODE_LO +: 3];
        nxt_cfg.meter_bus_sub_mode = sub_mode_t'(sub_raw);
        // An illegal sub-mode is flagged rather than silently remapped.
        case (sub_raw)
            SUB_LONG_HEADER, SUB_OTHER_TO_METER, SUB_METER_TO_OTHER, SUB_SHORT_HEADER: begin
                nxt_cfg.sub_mode_error = 1'b0;  // [RULE_09]
            end
            default: begin
                nxt_cfg.sub_mode_error = 1'b1;  // [RULE_09]
            end
        endcase
        nxt_cfg.rx_fifo_almost_full_level = regs[11][6:0];  // [RULE_10]
        nxt_cfg.rx_fifo_almost_empty_level = regs[12][6:0];  // [RULE_10]
        nxt_cfg.tx_fifo_almost_full_level = regs[13][6:0];  // [RULE_11]
        nxt_cfg.tx_fifo_almost_empty_level = regs[14][6:0];  // [RULE_11]
        nxt_cfg.control_field_mask_first = regs[15];
        nxt_cfg.control_filter_active = |regs[15];  // [RULE_12]
        nxt_cfg.length_mode_select = regs[16][POS_LEN_MODE];  // [RULE_13]
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign rdata_valid = rdata_valid_ff;
    assign rdata = rdata_ff;
    assign addr_hit = addr_hit_ff;
    assign cfg = cfg_ff;
endmodule
`default_nettype wire

// >>> testbench/host_model.sv
// Host side register access model for the packet configuration slice.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic                   clock,
    // Register access
    output var pkt_cfg_pkg::host_req_t host_req,
    input  wire logic                   rdata_valid,
    input  wire logic [7:0]             rdata
);
    import pkt_cfg_pkg::*;
    initial host_req = '0;
    // Released address and data lines show the inverse of their last value.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        host_req <= '{1'b1, 1'b0, a, d};
        @(posedge clock);
        host_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clock);
        host_req <= '{1'b0, 1'b1, a, host_req.wdata};
        @(posedge clock);
        host_req <= '{1'b0, 1'b0, ~a, ~host_req.wdata};
        #1;
        v = rdata_valid;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// >>> testbench/packet_config_chk.sv
// Concurrent checks on the ports of the packet configuration slice.
`timescale 1ns/100ps
`default_nettype none
module packet_config_chk (
    // Clock and reset
    input wire logic                   clock,
    input wire logic                   reset,
    // Host access and configuration
    input wire pkt_cfg_pkg::host_req_t host_req,
    input wire logic                   rdata_valid,
    input wire logic [7:0]             rdata,
    input wire logic                   addr_hit,
    input wire pkt_cfg_pkg::pkt_cfg_t  cfg
);
    import pkt_cfg_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Address of a write in this cycle, 0x00 when idle (unmapped).
    wire logic [7:0] wa = host_req.write ? host_req.addr : 8'h00;
    logic [7:0] wd;
    assign wd = host_req.wdata;
    a_read_answer: assert property (host_req.read |=> rdata_valid)
        else $error("read without valid");
    a_coding_fields: assert property (wa == 8'h33 |-> ##2 {cfg.whitening_enable,
        cfg.transmit_data_source, cfg.error_correction_enable} == {$past(wd[4:2], 2), $past(wd[0], 2)})
        else $error("coding fields wrong");
    a_length_pair: assert property ((wa == 8'h34 |-> ##2 cfg.packet_length[15:8] == $past(wd, 2))
        and (wa == 8'h35 |-> ##2 cfg.packet_length[7:0] == $past(wd, 2))) else $error("length wrong");
    a_quality_set: assert property (wa == 8'h3a |-> ##2 $past(wd, 2) == {cfg.sync_quality_threshold,
        cfg.preamble_quality_threshold, cfg.sync_quality_check_enable, cfg.preamble_quality_check_enable})
        else $error("quality wrong");
    a_amble_lengths: assert property ((wa == 8'h3b |-> ##2 cfg.meter_bus_preamble_length == $past(wd, 2))
        and (wa == 8'h3c |-> ##2 cfg.meter_bus_postamble_length == $past(wd, 2))) else $error("amble wrong");
    a_sub_flag: assert property (cfg.sub_mode_error == !(cfg.meter_bus_sub_mode inside {3'h0, 3'h1, 3'h3, 3'h5}))
        else $error("sub mode flag wrong");
    a_fifo_levels: assert property ((wa == 8'h3e |-> ##2 cfg.rx_fifo_almost_full_level == $past(wd[6:0], 2))
        and (wa == 8'h41 |-> ##2 cfg.tx_fifo_almost_empty_level == $past(wd[6:0], 2))) else $error("level wrong");
    a_mask_active: assert property (cfg.control_filter_active == (cfg.control_field_mask_first != 8'h00))
        else $error("filter flag wrong");
    a_length_mode: assert property (wa == 8'h32 |-> ##2 cfg.length_mode_select == $past(wd[0], 2))
        else $error("length mode wrong");
    a_reserved_zero: assert property (host_req.read && host_req.addr == 8'h3d |=> (rdata & 8'hf1) == 8'h00)
        else $error("reserved bits set");
    a_cfg_hold: assert property (!host_req.write |-> ##2 $stable(cfg))
        else $error("config changed without write");
    c_coding: cover property (wa == 8'h33);
    c_hit_read: cover property (rdata_valid && addr_hit);
    c_bad_mode: cover property (cfg.sub_mode_error);
endmodule
bind packet_config_register_slice packet_config_chk chk (.clock(clock), .reset(reset), .host_req(host_req),
    .rdata_valid(rdata_valid), .rdata(rdata), .addr_hit(addr_hit), .cfg(cfg));
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the packet configuration register slice.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pkt_cfg_pkg::*;
    logic       clock;
    logic       reset;
    host_req_t  host_req;
    logic       rdata_valid;
    logic [7:0] rdata;
    logic       addr_hit;
    pkt_cfg_t   cfg;
    int         miscompares;
    int         compares;
    logic [7:0] rst_val [17] = '{8'h00, 8'h00, 8'h00, 8'h14, 8'h88, 8'h88, 8'h88, 8'h88, 8'h02,
                                 8'h20, 8'h20, 8'h00, 8'h30, 8'h30, 8'h30, 8'h30, 8'h00};
    logic [7:0] wr_mask [17] = '{8'h01, 8'h1d, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                                 8'hff, 8'hff, 8'h0e, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hff};
    logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h3, 3'h5};
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    packet_config_register_slice dut (.clock(clock), .reset(reset), .host_req(host_req),
        .rdata_valid(rdata_valid), .rdata(rdata), .addr_hit(addr_hit), .cfg(cfg));
    host_model host (.clock(clock), .host_req(host_req), .rdata_valid(rdata_valid), .rdata(rdata));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
            miscompares++;
        end
    endtask
    // Compares valid, hit and data of one read together.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        logic [7:0] d;
        logic       v;
        host.rd(a, d, v);
        check("read", {22'h0, 1'b1, hit, exp}, {22'h0, v, addr_hit, d});
    endtask
    task automatic wr_cfg(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic reset_values;
        for (int i = 0; i < 17; i++) begin
            rd_chk(8'h32 + 8'(i), rst_val[i], 1'b1);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #50us;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        miscompares = 0;
        compares = 0;
        reset = 1'b1;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        reset_values();
        check("length", 32'h14, {16'h0, cfg.packet_length});
        check("sync_rst", 32'h88888888, cfg.sync_pattern);
        check("qual_rst", 32'h2, {30'h0, cfg.sync_quality_check_enable, cfg.preamble_quality_check_enable});
        for (int i = 0; i < 17; i++) begin
            host.wr(8'h32 + 8'(i), 8'hff);
            rd_chk(8'h32 + 8'(i), wr_mask[i], 1'b1);
        end
        check("len_mode", 32'h1, {31'h0, cfg.length_mode_select});
        host.wr(8'h31, 8'hff);
        rd_chk(8'h31, 8'h00, 1'b0);
        host.wr(8'h43, 8'hff);
        rd_chk(8'h43, 8'h00, 1'b0);
        for (int s = 0; s < 4; s++) begin
            wr_cfg(ADDR_CODING_CTRL, {3'h7, 1'(s), 2'(s), 1'b1, 1'(s >> 1)});
            check("source", s, {30'h0, cfg.transmit_data_source});
            check("whit_fec", {30'h0, 1'(s), 1'(s >> 1)}, {30'h0, cfg.whitening_enable, cfg.error_correction_enable});
        end
        for (int m = 0; m < 4; m++) begin
            wr_cfg(ADDR_METER_BUS_CONTROL, {4'hf, modes[m], 1'b1});
            check("sub_mode", {29'h0, modes[m]}, {28'h0, cfg.sub_mode_error, cfg.meter_bus_sub_mode});
        end
        wr_cfg(ADDR_METER_BUS_CONTROL, 8'h04);
        check("mode_err", 32'h1, {31'h0, cfg.sub_mode_error});
        wr_cfg(ADDR_QUALITY, 8'hc5);
        check("quality", 32'hc5, {24'h0, cfg.sync_quality_threshold, cfg.preamble_quality_threshold,
            cfg.sync_quality_check_enable, cfg.preamble_quality_check_enable});
        host.wr(ADDR_LEN_HIGH, 8'hab);
        wr_cfg(ADDR_LEN_LOW, 8'hcd);
        check("length", 32'habcd, {16'h0, cfg.packet_length});
        host.wr(ADDR_SYNC_4, 8'h12);
        host.wr(ADDR_SYNC_3, 8'h34);
        host.wr(ADDR_SYNC_2, 8'h56);
        wr_cfg(ADDR_SYNC_1, 8'h78);
        check("sync", 32'h12345678, cfg.sync_pattern);
        host.wr(ADDR_MBUS_PREAMBLE, 8'h01);
        wr_cfg(ADDR_MBUS_POSTAMB, 8'hfe);
        check("ambles", 32'h01fe, {16'h0, cfg.meter_bus_preamble_length, cfg.meter_bus_postamble_length});
        host.wr(ADDR_RX_AF, 8'h81);
        host.wr(ADDR_RX_AE, 8'h02);
        host.wr(ADDR_TX_AF, 8'h7f);
        wr_cfg(ADDR_TX_AE, 8'h00);
        check("rx_lvl", 32'h82, {18'h0, cfg.rx_fifo_almost_full_level, cfg.rx_fifo_almost_empty_level});
        check("tx_lvl", 32'h3f80, {18'h0, cfg.tx_fifo_almost_full_level, cfg.tx_fifo_almost_empty_level});
        wr_cfg(ADDR_CTRL_MASK_0, 8'h80);
        check("filter_on", 32'h1, {31'h0, cfg.control_filter_active});
        check("mask", 32'h80, {24'h0, cfg.control_field_mask_first});
        wr_cfg(ADDR_CTRL_MASK_0, 8'h00);
        check("filter_off", 32'h0, {31'h0, cfg.control_filter_active});
        wr_cfg(ADDR_LEN_MODE, 8'hfe);
        check("len_mode", 32'h0, {31'h0, cfg.length_mode_select});
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        reset_values();
        tally_and_finish();
    end
endmodule
`default_nettype wire
